// ===== hw/epg_programmer.sv
// programmer controller driving an erasable read-only memory through its pins
// Behaviour
// (RULE1) erased cells read one; programming only clears selected bits to zero
// (RULE2) no electrical operation returns a zero bit to one
// (RULE3) programming needs raised supply and select low; all 8 data bits in parallel
// (RULE4) each initial pulse is select low for 1.0 ms, within 0.95 to 1.05 ms
// (RULE5) verify after every initial pulse; at most 25 initial pulses per byte
// (RULE6) after a good verify, one overprogram pulse of 3 ms times the pulse count
// (RULE7) overprogram pulse lies between 2.85 ms and 78.75 ms
// (RULE8) pulses and per-byte verifies run with core 6V and programming supply 12.5V
// (RULE9) final compare of every byte runs with both supplies at 5V
// (RULE10) a device with select high is not programmed
// (RULE11) standard verify: gate low, select high, programming supply raised
// (RULE12) with raised supply the device drives whenever the gate is low
// (RULE13) parallel devices on one bus verify at 6V supply in normal read mode
// (RULE14) identifier read: high voltage on address bit nine, other lines low but bit zero
// (RULE15) identifier byte 0 is the maker code, byte 1 the device code
// (RULE16) identifier bytes have odd parity, data_msb being the parity bit
// (RULE17) read drives data only with select and gate both low
// (RULE18) select high in read conditions means standby and floating outputs
// (RULE19) a byte failing after the last initial pulse stops programming and reports failure
// (RULE20) address and data change only while select is high
`default_nettype none

module epg_programmer #(
	parameter int unsigned INIT_PULSE_CYC = epg_pkg::PW_CYC,
	parameter int unsigned OVER_UNIT_CYC  = epg_pkg::OPW_UNIT_CYC,
	parameter int unsigned MAX_PULSES     = epg_pkg::MAX_PULSES
) (
	// clocking
	input  wire logic                         core_clk,
	input  wire logic                         rst,
	input  wire logic                         clkEn,
	// user command
	input  wire logic                         cmdValid,
	input  wire logic [1:0]                   cmdOp,
	input  wire logic [epg_pkg::ADDR_W-1:0]   cmdAddr,
	input  wire logic [epg_pkg::DATA_W-1:0]   cmdData,
	input  wire logic                         parMode,
	input  wire logic                         clearFail,
	output logic                              cmdReady,
	// user answer
	output logic                              rspValid,
	output logic                              rspOk,
	output logic      [epg_pkg::DATA_W-1:0]   rspData,
	output logic      [4:0]                   rspIter,
	output logic                              deviceFail,
	// device pins
	output logic      [epg_pkg::ADDR_W-1:0]   addrPin,
	input  wire logic [epg_pkg::DATA_W-1:0]   dataIn,
	output logic      [epg_pkg::DATA_W-1:0]   dataOut,
	output logic                              dataOe,
	output logic                              chipSelN,
	output logic                              outGateN,
	// supply switches: 12.5V programming supply, 6V core, high voltage on bit nine
	output logic                              vppProg,
	output logic                              vccProg,
	output logic                              addressBitNineHv
);
	typedef enum logic [6:0] {
		S_IDLE    = 7'h01,
		S_SETUP   = 7'h02,
		S_PULSE   = 7'h04,
		S_HOLD    = 7'h08,
		S_VERIFY  = 7'h10,
		S_READ    = 7'h20,
		S_RECOVER = 7'h40
	} epg_state_t;

	typedef epg_pkg::epg_op_t epg_op_t_w;

	epg_state_t                  state_q;
	epg_op_t_w                   op_q;
	logic [31:0]                 timer_q;
	logic [4:0]                  iter_q;
	logic                        passed_q;
	logic                        finish_q;
	logic                        setFail;
	logic [epg_pkg::DATA_W-1:0]  syncData;

	epg_sync #(
		.W (epg_pkg::DATA_W)
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.clkEn    (clkEn),
		.pinIn    (dataIn),
		.pinOut   (syncData)
	);

	wire logic tDone = (timer_q == 32'h0000_0000);
	wire logic match = (syncData == dataOut);
	assign setFail = clkEn && (state_q == S_VERIFY) && tDone && !match
		&& (iter_q >= 5'(MAX_PULSES));

	function automatic logic [31:0] cyc(input int unsigned n);
		cyc = 32'(n - 1);
	endfunction

	// sticky failure: a new failure wins over a clear in the same cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			deviceFail <= 1'b0;
		end else if (clkEn) begin
			if (setFail) begin
				deviceFail <= 1'b1; // RULE19
			end else if (clearFail) begin
				deviceFail <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= S_IDLE;
			op_q <= epg_pkg::EPG_OP_PROG;
			timer_q <= 32'h0000_0000;
			iter_q <= 5'h00;
			passed_q <= 1'b0;
			finish_q <= 1'b0;
			cmdReady <= 1'b0;
			rspValid <= 1'b0;
			rspOk <= 1'b0;
			rspData <= 8'h00;
			rspIter <= 5'h00;
			addrPin <= '0;
			dataOut <= 8'h00;
			dataOe <= 1'b0;
			chipSelN <= 1'b1;
			outGateN <= 1'b1;
			vppProg <= 1'b0;
			vccProg <= 1'b0;
			addressBitNineHv <= 1'b0;
		end else if (clkEn) begin
			rspValid <= 1'b0;
			if (!tDone) begin
				timer_q <= timer_q - 32'h0000_0001;
			end
			case (state_q)
				S_IDLE: begin
					cmdReady <= 1'b1;
					if (cmdValid && cmdReady) begin
						cmdReady <= 1'b0;
						op_q <= epg_op_t_w'(cmdOp);
						iter_q <= 5'h00;
						passed_q <= 1'b0;
						finish_q <= 1'b0;
						timer_q <= cyc(epg_pkg::SETUP_CYC);
						state_q <= S_SETUP;
						// address and data settle while select is still high
						addrPin <= cmdAddr; // RULE20
						dataOut <= cmdData;
						if (epg_op_t_w'(cmdOp) == epg_pkg::EPG_OP_PROG) begin
							if (deviceFail) begin
								// refused: the device already failed
								rspValid <= 1'b1; // RULE19
								rspOk <= 1'b0;
								rspIter <= 5'h00;
								cmdReady <= 1'b1;
								state_q <= S_IDLE;
							end else begin
								dataOe <= 1'b1; // RULE3
								vppProg <= 1'b1; // RULE8
								vccProg <= 1'b1;
							end
						end else if (epg_op_t_w'(cmdOp) == epg_pkg::EPG_OP_ID) begin
							addrPin <= '0; // RULE14
							addrPin[epg_pkg::ID_SEL_BIT] <= cmdAddr[epg_pkg::ID_SEL_BIT];
							addressBitNineHv <= 1'b1;
						end else begin
							// final compare at 5V, or 6V core for shared-bus parallel verify
							vccProg <= parMode; // RULE9 RULE13
						end
					end
				end
				S_SETUP: begin
					if (tDone) begin
						chipSelN <= 1'b0;
						if (op_q != epg_pkg::EPG_OP_PROG) begin
							outGateN <= 1'b0; // RULE17
							timer_q <= cyc(epg_pkg::READ_CYC);
							state_q <= S_READ;
						end else if (passed_q) begin
							timer_q <= 32'(OVER_UNIT_CYC * iter_q) - 32'h0000_0001; // RULE6 RULE7
							state_q <= S_PULSE;
						end else begin
							timer_q <= cyc(INIT_PULSE_CYC); // RULE4
							iter_q <= iter_q + 5'h01; // RULE5
							state_q <= S_PULSE;
						end
					end
				end
				S_PULSE: begin
					if (tDone) begin
						chipSelN <= 1'b1;
						timer_q <= cyc(epg_pkg::SETUP_CYC);
						state_q <= S_HOLD;
					end
				end
				S_HOLD: begin
					// data hold after the pulse, then the gate setup before verify
					if (tDone) begin
						dataOe <= 1'b0;
						if (passed_q) begin
							vppProg <= 1'b0;
							vccProg <= 1'b0;
							rspValid <= 1'b1;
							rspOk <= 1'b1;
							rspIter <= iter_q;
							cmdReady <= 1'b1;
							state_q <= S_IDLE;
						end else begin
							outGateN <= 1'b0; // RULE11
							timer_q <= cyc(epg_pkg::READ_CYC);
							state_q <= S_VERIFY;
						end
					end
				end
				S_VERIFY: begin
					if (tDone) begin
						outGateN <= 1'b1;
						passed_q <= match; // RULE5
						finish_q <= !match && (iter_q >= 5'(MAX_PULSES)); // RULE19
						rspData <= syncData;
						timer_q <= cyc(epg_pkg::FLOAT_CYC);
						state_q <= S_RECOVER;
					end
				end
				S_READ: begin
					if (tDone) begin
						rspData <= syncData;
						outGateN <= 1'b1;
						chipSelN <= 1'b1; // RULE18
						finish_q <= 1'b1;
						timer_q <= cyc(epg_pkg::FLOAT_CYC);
						state_q <= S_RECOVER;
					end
				end
				S_RECOVER: begin
					// device outputs float before data is driven again
					if (tDone) begin
						if (finish_q) begin
							vppProg <= 1'b0;
							vccProg <= 1'b0;
							addressBitNineHv <= 1'b0;
							rspValid <= 1'b1;
							rspIter <= iter_q;
							if (op_q == epg_pkg::EPG_OP_ID) begin
								rspOk <= ^rspData; // RULE15 RULE16
							end else if (op_q != epg_pkg::EPG_OP_PROG) begin
								// the unused op code runs as a plain read and compare
								rspOk <= (rspData == dataOut);
							end else begin
								rspOk <= 1'b0;
							end
							cmdReady <= 1'b1;
							state_q <= S_IDLE;
						end else begin
							dataOe <= 1'b1;
							timer_q <= cyc(epg_pkg::SETUP_CYC);
							state_q <= S_SETUP;
						end
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// helper: length of the current select-low stretch in enabled cycles
	logic [31:0] lowCnt;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lowCnt <= 32'h0000_0000;
		end else if (clkEn) begin
			lowCnt <= chipSelN ? 32'h0000_0000 : lowCnt + 32'h0000_0001;
		end
	end

	property p_pulseWidth;
		@(posedge core_clk) disable iff (rst)
		$rose(chipSelN) && vppProg && !passed_q && (INIT_PULSE_CYC == epg_pkg::PW_CYC)
			|-> lowCnt >= epg_pkg::PW_MIN_CYC && lowCnt <= epg_pkg::PW_MAX_CYC;
	endproperty
	a_pulseWidth: assert property (p_pulseWidth) else $error("initial pulse width out of range"); // RULE4

	property p_overWidth;
		@(posedge core_clk) disable iff (rst)
		$rose(chipSelN) && vppProg && passed_q
			|-> lowCnt == OVER_UNIT_CYC * iter_q;
	endproperty
	a_overWidth: assert property (p_overWidth) else $error("overprogram width not 3 ms per pulse"); // RULE6

	property p_overRange;
		@(posedge core_clk) disable iff (rst)
		$rose(chipSelN) && vppProg && passed_q && (OVER_UNIT_CYC == epg_pkg::OPW_UNIT_CYC)
			|-> lowCnt >= epg_pkg::OPW_MIN_CYC && lowCnt <= epg_pkg::OPW_MAX_CYC;
	endproperty
	a_overRange: assert property (p_overRange) else $error("overprogram pulse out of range"); // RULE7

	property p_iterMax;
		@(posedge core_clk) disable iff (rst)
		iter_q <= 5'(MAX_PULSES);
	endproperty
	a_iterMax: assert property (p_iterMax) else $error("too many initial pulses"); // RULE5

	property p_progSupply;
		@(posedge core_clk) disable iff (rst)
		(!chipSelN && dataOe) |-> (vppProg && vccProg && outGateN);
	endproperty
	a_progSupply: assert property (p_progSupply) else $error("pulse without program supplies"); // RULE8

	property p_stableUnderSelect;
		@(posedge core_clk) disable iff (rst)
		(!chipSelN && $past(!chipSelN)) |-> ($stable(addrPin) && $stable(dataOut));
	endproperty
	a_stableUnderSelect: assert property (p_stableUnderSelect) else $error("pins moved in pulse"); // RULE20

	property p_stdVerify;
		@(posedge core_clk) disable iff (rst)
		(vppProg && !outGateN) |-> (chipSelN && !dataOe && vccProg);
	endproperty
	a_stdVerify: assert property (p_stdVerify) else $error("verify not in standard form"); // RULE11

	property p_idAddr;
		@(posedge core_clk) disable iff (rst)
		addressBitNineHv |-> ((addrPin >> 1) == '0) && !vppProg;
	endproperty
	a_idAddr: assert property (p_idAddr) else $error("identifier read with address lines high"); // RULE14

	property p_failCause;
		@(posedge core_clk) disable iff (rst)
		$rose(deviceFail) |-> $past(iter_q) == 5'(MAX_PULSES);
	endproperty
	a_failCause: assert property (p_failCause) else $error("failure before last pulse"); // RULE19

	property p_readSupply;
		@(posedge core_clk) disable iff (rst)
		(state_q == S_READ) |-> (!vppProg && vccProg == $past(vccProg, 1)) ##1 !vppProg;
	endproperty
	a_readSupply: assert property (p_readSupply) else $error("read with programming supply"); // RULE9 RULE13

	c_prog:  cover property (@(posedge core_clk) disable iff (rst) rspValid && rspOk && vppProg == 1'b0
		&& op_q == epg_pkg::EPG_OP_PROG);
	c_fail:  cover property (@(posedge core_clk) disable iff (rst) $rose(deviceFail));
	c_id:    cover property (@(posedge core_clk) disable iff (rst) rspValid && op_q == epg_pkg::EPG_OP_ID);
	c_retry: cover property (@(posedge core_clk) disable iff (rst) iter_q == 5'h02 && state_q == S_VERIFY);
endmodule

`default_nettype wire

// ===== hw/epg_pkg.sv
// package of pin timing constants plus the three-stage pin input synchroniser
`default_nettype none

package epg_pkg;
	localparam int unsigned CLK_PERIOD_PS = 8000;
	// pulse and setup times as specified, in ns
	localparam int unsigned T_PW_NS       = 1000000;
	localparam int unsigned T_PW_MIN_NS   = 950000;
	localparam int unsigned T_PW_MAX_NS   = 1050000;
	localparam int unsigned T_OPW_UNIT_NS = 3000000;
	localparam int unsigned T_OPW_MIN_NS  = 2850000;
	localparam int unsigned T_OPW_MAX_NS  = 78750000;
	localparam int unsigned T_SETUP_NS    = 2000;
	localparam int unsigned T_OE_NS       = 150;
	localparam int unsigned T_FLOAT_NS    = 130;
	// least times round up, longest round down
	localparam int unsigned PW_CYC       = (T_PW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned PW_MIN_CYC   = (T_PW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned PW_MAX_CYC   = (T_PW_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned OPW_UNIT_CYC = (T_OPW_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned OPW_MIN_CYC  = (T_OPW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// ns times 1000 would overflow 32 bits here, so divide by the period in ns instead
	localparam int unsigned OPW_MAX_CYC  = T_OPW_MAX_NS / (CLK_PERIOD_PS / 1000);
	localparam int unsigned SETUP_CYC    = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned FLOAT_CYC    = (T_FLOAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned SYNC_LAT     = 4;
	localparam int unsigned READ_CYC     =
		(T_OE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + SYNC_LAT;
	localparam int unsigned MAX_PULSES   = 25;
	localparam int unsigned ADDR_W       = 15;
	localparam int unsigned DATA_W       = 8;
	localparam int unsigned ID_SEL_BIT   = 0;

	typedef enum logic [1:0] {
		EPG_OP_PROG = 2'h0,
		EPG_OP_READ = 2'h1,
		EPG_OP_ID   = 2'h2
	} epg_op_t;
endpackage

// pin synchroniser: three flops and an output flop, a bit changes once stages two and three agree
module epg_sync #(
	parameter int unsigned W = 8
) (
	// clocking
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         clkEn,
	// pins and result
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinOut
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else if (clkEn) begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				pinOut[i] <= 1'b0;
			end else if (clkEn && (s2_q[i] == s3_q[i])) begin
				pinOut[i] <= s3_q[i];
			end
		end
	end
endmodule

`default_nettype wire

// ===== verif/epg_eprom_model.sv
// pin-level behavioural model of the erasable memory on the far side
`default_nettype none

module epg_eprom_model #(
	parameter logic [7:0] MAKER_CODE = 8'h31, // arbitrary value, odd parity
	parameter logic [7:0] PART_CODE  = 8'h8A  // arbitrary value, odd parity
) (
	// pins driven by the programmer
	input  wire logic [14:0] addrPin,
	input  wire logic [7:0]  dataPin,
	input  wire logic        dataOe,
	input  wire logic        chipSelN,
	input  wire logic        outGateN,
	// supplies
	input  wire logic        vppProg,
	input  wire logic        vccProg,
	input  wire logic        addressBitNineHv,
	// bench controls
	input  wire logic [7:0]  needPulses,
	input  wire logic        badParity,
	// device side of the data bus
	output logic      [7:0]  devBus,
	output logic             devDrive
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] mem [0:32767];
	logic [7:0] floatVal = 8'h5A;
	logic [7:0] devData;
	logic [7:0] hits = 8'h00;
	time        fallT = 0;
	int         errCount = 0;
	int         pulseNs [$];

	initial begin
		for (int i = 0; i < 32768; i++) begin
			mem[i] = 8'hFF;
		end
	end

	always @(posedge vppProg) hits = 8'h00;

	always @(negedge chipSelN) begin
		fallT = $time;
		if (vppProg && !vccProg) errCount++;
	end

	// only a select-low pulse under raised supply writes, and it can only clear bits
	always @(posedge chipSelN) begin
		if (vppProg === 1'b1) begin
			pulseNs.push_back(int'($time - fallT));
			hits = hits + 8'h01;
			if (!dataOe) errCount++;
			if (hits >= needPulses) mem[addrPin] = mem[addrPin] & dataPin;
		end
	end

	always @(addrPin or dataPin) begin
		if (chipSelN === 1'b0 && vppProg === 1'b1) errCount++;
	end

	always @(negedge outGateN) begin
		if (addressBitNineHv && (addrPin & 15'h7DFE) !== 15'h0000) errCount++;
	end

	always @* begin
		if (vppProg) devDrive = !outGateN;
		else devDrive = !chipSelN && !outGateN;
		if (addressBitNineHv) devData = addrPin[0] ? (PART_CODE ^ {badParity, 7'h00}) : MAKER_CODE;
		else devData = mem[addrPin];
	end

	// a released bus shows the inverse of the last value so stale data cannot pass
	always @(negedge devDrive) floatVal = ~devData;
	always @(posedge devDrive or posedge dataOe) begin
		if (devDrive && dataOe) errCount++;
	end
	assign devBus = devDrive ? devData : floatVal;
endmodule

`default_nettype wire

// ===== verif/tb_epg_programmer.sv
// self-checking bench for the programmer controller against the memory model
`default_nettype none

module tb_epg_programmer;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int IPC = 50;
	localparam int OUC = 150;
	localparam int MXP = 3;
	localparam int LIM = 20000;

	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        clkEn = 1'b1;
	logic        cmdValid = 1'b0;
	logic [1:0]  cmdOp = 2'h0;
	logic [14:0] cmdAddr = 15'h0000;
	logic [7:0]  cmdData = 8'h00;
	logic        parMode = 1'b0;
	logic        clearFail = 1'b0;
	logic [7:0]  needPulses = 8'h01;
	logic        badParity = 1'b0;
	logic        cmdReady, rspValid, rspOk, deviceFail, dataOe, chipSelN, outGateN;
	logic        vppProg, vccProg, addressBitNineHv, devDrive;
	logic [7:0]  rspData, dataOut, devBus;
	wire  [7:0]  dataIn;
	logic [4:0]  rspIter;
	logic [14:0] addrPin;
	int          fail_count = 0;
	int          check_count = 0;

	always #4 core_clk = ~core_clk;
	assign dataIn = dataOe ? dataOut : devBus;

	epg_programmer #(.INIT_PULSE_CYC(IPC), .OVER_UNIT_CYC(OUC), .MAX_PULSES(MXP)) i_epg_programmer (
		.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .cmdValid(cmdValid), .cmdOp(cmdOp),
		.cmdAddr(cmdAddr), .cmdData(cmdData), .parMode(parMode), .clearFail(clearFail),
		.cmdReady(cmdReady), .rspValid(rspValid), .rspOk(rspOk), .rspData(rspData),
		.rspIter(rspIter), .deviceFail(deviceFail), .addrPin(addrPin), .dataIn(dataIn),
		.dataOut(dataOut), .dataOe(dataOe), .chipSelN(chipSelN), .outGateN(outGateN),
		.vppProg(vppProg), .vccProg(vccProg), .addressBitNineHv(addressBitNineHv));

	epg_eprom_model i_epg_eprom_model (
		.addrPin(addrPin), .dataPin(dataOut), .dataOe(dataOe), .chipSelN(chipSelN),
		.outGateN(outGateN), .vppProg(vppProg), .vccProg(vccProg),
		.addressBitNineHv(addressBitNineHv), .needPulses(needPulses),
		.badParity(badParity), .devBus(devBus), .devDrive(devDrive));

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic bad(input string m);
		fail_count++;
		$display("BAD %0t %s", $time, m);
	endtask

	task automatic chkBit(input logic got, input logic exp, input string m);
		check_count++;
		if (got !== exp) bad(m);
	endtask

	task automatic chkByte(input logic [7:0] got, input logic [7:0] exp, input string m);
		check_count++;
		if (got !== exp) bad(m);
	endtask

	task automatic chkNum(input int got, input int exp, input string m);
		check_count++;
		if (got != exp) bad(m);
	endtask

	// requests are raised after an edge and held until the edge that takes them
	task automatic issue(input epg_pkg::epg_op_t op, input logic [14:0] a, input logic [7:0] d,
			input logic pm);
		int n;
		n = 0;
		while (cmdReady !== 1'b1 && n < LIM) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n >= LIM) begin
			bad("never ready");
			results();
		end
		cmdOp = op;
		cmdAddr = a;
		cmdData = d;
		parMode = pm;
		cmdValid = 1'b1;
		@(posedge core_clk);
		#1;
		cmdValid = 1'b0;
		n = 0;
		while (rspValid !== 1'b1 && n < LIM) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n >= LIM) begin
			bad("no answer");
			results();
		end
	endtask

	// initial pulses first, then the overprogram pulse if the byte passed
	task automatic checkPulses(input int x, input bit over);
		chkNum(i_epg_eprom_model.pulseNs.size(), x + int'(over), "pulse count");
		foreach (i_epg_eprom_model.pulseNs[i]) begin
			chkNum(i_epg_eprom_model.pulseNs[i], (i < x) ? IPC * 8 : x * OUC * 8, "width");
		end
		i_epg_eprom_model.pulseNs.delete();
	endtask

	task automatic tErased();
		issue(epg_pkg::EPG_OP_READ, 15'h1234, 8'hFF, 1'b0);
		chkBit(rspOk, 1'b1, "erased ok");
		chkByte(rspData, 8'hFF, "erased data");
		chkByte({3'h0, rspIter}, 8'h00, "read iter");
		issue(epg_pkg::epg_op_t'(2'h3), 15'h0100, 8'hFF, 1'b0);
		chkBit(rspOk, 1'b1, "spare op read ok");
		chkByte(rspData, 8'hFF, "spare op data");
		$display("erased read done");
	endtask

	task automatic tProg(input logic [14:0] a, input logic [7:0] d, input int x);
		needPulses = 8'(x);
		issue(epg_pkg::EPG_OP_PROG, a, d, 1'b0);
		chkBit(rspOk, 1'b1, "prog ok");
		chkByte({3'h0, rspIter}, 8'(x), "prog iter");
		checkPulses(x, 1'b1);
		issue(epg_pkg::EPG_OP_READ, a, d, x[0]);
		chkBit(rspOk, 1'b1, "readback ok");
		chkByte(rspData, d, "readback data");
		$display("program with %0d pulses done", x);
	endtask

	task automatic tStuck();
		needPulses = 8'h01;
		issue(epg_pkg::EPG_OP_PROG, 15'h1234, 8'hFF, 1'b0);
		chkBit(rspOk, 1'b0, "stuck ok");
		chkBit(deviceFail, 1'b1, "fail flag");
		chkByte({3'h0, rspIter}, 8'(MXP), "stuck iter");
		checkPulses(MXP, 1'b0);
		issue(epg_pkg::EPG_OP_PROG, 15'h0001, 8'h00, 1'b0);
		chkBit(rspOk, 1'b0, "refused ok");
		chkByte({3'h0, rspIter}, 8'h00, "refused iter");
		checkPulses(0, 1'b0);
		@(posedge core_clk);
		#1;
		clearFail = 1'b1;
		@(posedge core_clk);
		#1;
		clearFail = 1'b0;
		@(posedge core_clk);
		#1;
		chkBit(deviceFail, 1'b0, "fail cleared");
		issue(epg_pkg::EPG_OP_READ, 15'h0001, 8'hFF, 1'b0);
		chkByte(rspData, 8'hFF, "refused untouched");
		issue(epg_pkg::EPG_OP_READ, 15'h1234, 8'hA5, 1'b0);
		chkByte(rspData, 8'hA5, "zero stays");
		$display("stuck byte done");
	endtask

	task automatic tIdent();
		issue(epg_pkg::EPG_OP_ID, 15'h0000, 8'h00, 1'b0);
		chkBit(rspOk, 1'b1, "maker parity");
		chkByte(rspData, i_epg_eprom_model.MAKER_CODE, "maker code");
		issue(epg_pkg::EPG_OP_ID, 15'h0001, 8'h00, 1'b0);
		chkBit(rspOk, 1'b1, "part parity");
		chkByte(rspData, i_epg_eprom_model.PART_CODE, "part code");
		badParity = 1'b1;
		issue(epg_pkg::EPG_OP_ID, 15'h0001, 8'h00, 1'b0);
		chkBit(rspOk, 1'b0, "even parity refused");
		badParity = 1'b0;
		$display("identifier done");
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		#1;
		rst = 1'b0;
		tErased();
		tProg(15'h1234, 8'hA5, 1);
		tProg(15'h0007, 8'h3C, 2);
		tStuck();
		tIdent();
		chkNum(i_epg_eprom_model.errCount, 0, "pin protocol");
		results();
	end
endmodule

`default_nettype wire
